// [core/wdt_pwr_ctrl.sv]
// What this block does
// - watchdog counter advances on the low-power RC clock enable, not the system clock
// - watchdog fuse enable at 1 forces the watchdog on; erased fuse reads 1
// - enabled watchdog counts to overflow; overflow in run resets the device
// - clear-watchdog instruction restarts the count from zero
// - with fuse enable 0, soft enable bit 5 of reset control starts or stops it
// - time-out in sleep wakes the device and sets sleep and time-out flags
// - power-save instruction enters sleep or idle by its operand
// - sleep gates cpu and peripheral clocks and stops the on-chip oscillator unless a kept low-power crystal is selected
// - clock-fail monitor off in sleep; low-power rc runs if watchdog operates
// - sleep ends on enabled interrupt at priority, any reset, or watchdog time-out
// - wake restarts previous clock; after power-on or brown-out fuses choose
// - crystal wake waits start-up timer, pll waits lock; por and powerup delays apply
// - external, fast rc, low-power rc, external rc wake applies only the 10 us delay
// - low-power crystal kept through sleep wakes with only the power-on delay
// - interrupt wake from sleep vectors to the handler and sets the sleep flag
// - any reset wakes sleep; external and software resets set sleep flag, power-on clears it
// - idle stops only the cpu clock and ends on the same events as sleep
// - idle wake restores cpu clock at once and resumes after the instruction
// - idle flag set by interrupt wake or external or software reset; wdt idle wake sets both
// - config words are 24 bits with low 16 used, readable by table read
// - module-disable bit takes effect one instruction cycle after write
// - peripheral runs only if present and not disabled; present ones default enabled
`default_nettype none
module wdt_pwr_ctrl #(
  parameter int wdt_width = 16,
  parameter int powerup_timer_cycles = 640,
  parameter logic [15:0] present_mask1 = 16'hffff,
  parameter logic [15:0] present_mask2 = 16'hffff,
  parameter logic [15:0] fuse_osc = 16'hffff,
  parameter logic [15:0] fuse_wdt = 16'hffff,
  parameter logic [15:0] fuse_borpor = 16'hffff,
  parameter logic [15:0] fuse_gs = 16'hffff,
  parameter logic [15:0] fuse_icd = 16'hffff
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire wdt_pwr_pkg::reset_req_t reset_req,
  input wire logic low_power_rc_osc_tick,
  input wire logic clear_watchdog_instr,
  input wire logic power_save_instr,
  input wire logic [1:0] power_save_operand,
  input wire logic int_wake_req,
  input wire logic clock_switch_en,
  input wire logic [2:0] current_osc_select,
  input wire logic low_power_crystal_keep,
  input wire logic osc_startup_done,
  input wire logic pll_lock,
  input wire wdt_pwr_pkg::sfr_bus_t sfr,
  output logic [15:0] sfr_rdata,
  input wire logic [23:0] table_addr,
  output logic [23:0] table_rdata,
  output logic device_reset,
  output logic cpu_clk_en,
  output logic periph_clk_en,
  output logic osc_run,
  output logic [2:0] wake_osc_select,
  output logic clock_fail_monitor_en,
  output logic low_power_rc_osc_en,
  output logic vector_to_handler,
  output logic [31:0] periph_run
);
  // the wake delay counter is 16 bits wide
  if (wdt_width < 2 || wdt_width > 24 || powerup_timer_cycles < 1 || powerup_timer_cycles > 65535)
  begin : g_bad
    $error("wdt_pwr_ctrl: unsupported parameter");
  end

  typedef struct packed {
    wdt_pwr_pkg::pwr_state_t st;
    logic [wdt_width-1:0] wdt;
    logic [15:0] reset_control_reg;
    logic [15:0] md1;
    logic [15:0] md2;
    logic [31:0] run;
    logic [15:0] delay;
    logic need_osc;
    logic need_powerup_timer;
    logic [2:0] wsrc;
    logic rst_out;
    logic vec;
    logic fuse_sel;
  } state_t;

  state_t s_r;
  state_t s_nxt;
  logic wdt_on;
  logic wdt_ovf;
  logic any_rst;
  logic [2:0] fuse_src;

  assign wdt_on = fuse_wdt[wdt_pwr_pkg::wdt_fuse_bit] | s_r.reset_control_reg[wdt_pwr_pkg::rc_soft_en_bit];
  assign wdt_ovf = wdt_on & low_power_rc_osc_tick & (&s_r.wdt);
  assign any_rst = reset_req.por | reset_req.bor | reset_req.ext | reset_req.sw;
  assign fuse_src = fuse_osc[wdt_pwr_pkg::osc_group_lsb +: 3];

  always_comb
  begin
    s_nxt = s_r;
    s_nxt.rst_out = 1'b0;
    s_nxt.vec = 1'b0;
    if (clear_watchdog_instr || !wdt_on)
    begin
      s_nxt.wdt = '0;
    end
    else if (low_power_rc_osc_tick)
    begin
      s_nxt.wdt = s_r.wdt + 1'b1;
    end
    // register writes land one cycle ahead of the gate update
    if (sfr.we)
    begin
      case (sfr.addr)
        wdt_pwr_pkg::reset_control_addr: s_nxt.reset_control_reg = sfr.wdata;
        wdt_pwr_pkg::module_disable1_addr: s_nxt.md1 = sfr.wdata;
        wdt_pwr_pkg::module_disable2_addr: s_nxt.md2 = sfr.wdata;
        default: s_nxt.md1 = s_nxt.md1;
      endcase
    end
    s_nxt.run = {present_mask2 & ~s_r.md2, present_mask1 & ~s_r.md1};
    case (s_r.st)
      wdt_pwr_pkg::st_run:
      begin
        if (power_save_instr && !any_rst && !wdt_ovf)
        begin
          if (power_save_operand == wdt_pwr_pkg::power_save_instr_sleep)
          begin
            s_nxt.st = wdt_pwr_pkg::st_sleep;
            s_nxt.need_osc = !(current_osc_select == wdt_pwr_pkg::src_low_power_crystal
                               && low_power_crystal_keep);
          end
          else
          begin
            s_nxt.st = wdt_pwr_pkg::st_idle;
          end
        end
      end
      wdt_pwr_pkg::st_idle:
      begin
        if (wdt_ovf)
        begin
          s_nxt.st = wdt_pwr_pkg::st_run;
          s_nxt.reset_control_reg[wdt_pwr_pkg::rc_idle_bit] = 1'b1;
          s_nxt.reset_control_reg[wdt_pwr_pkg::rc_watchdog_timeout_flag_bit] = 1'b1;
        end
        else if (int_wake_req)
        begin
          s_nxt.st = wdt_pwr_pkg::st_run;
          s_nxt.vec = 1'b1;
          s_nxt.reset_control_reg[wdt_pwr_pkg::rc_idle_bit] = 1'b1;
        end
      end
      wdt_pwr_pkg::st_sleep:
      begin
        if (wdt_ovf || int_wake_req)
        begin
          s_nxt.st = wdt_pwr_pkg::st_wake_por;
          s_nxt.delay = 16'(wdt_pwr_pkg::por_delay_cyc);
          s_nxt.fuse_sel = 1'b0;
          s_nxt.wsrc = current_osc_select;
          s_nxt.reset_control_reg[wdt_pwr_pkg::rc_sleep_bit] = 1'b1;
          s_nxt.vec = int_wake_req & ~wdt_ovf;
          if (wdt_ovf)
          begin
            s_nxt.reset_control_reg[wdt_pwr_pkg::rc_watchdog_timeout_flag_bit] = 1'b1;
          end
        end
      end
      wdt_pwr_pkg::st_wake_por:
      begin
        // power-on delay always; oscillator waits only for crystals
        if (s_r.delay <= 16'h0001)
        begin
          s_nxt.st = (s_r.need_osc && (s_r.wsrc == wdt_pwr_pkg::src_crystal
                      || s_r.wsrc == wdt_pwr_pkg::src_crystal_pll
                      || s_r.wsrc == wdt_pwr_pkg::src_low_power_crystal))
                     ? wdt_pwr_pkg::st_wake_osc : wdt_pwr_pkg::st_run;
        end
        else
        begin
          s_nxt.delay = s_r.delay - 16'h0001;
        end
      end
      wdt_pwr_pkg::st_wake_osc:
      begin
        if (osc_startup_done && (s_r.wsrc != wdt_pwr_pkg::src_crystal_pll || pll_lock))
        begin
          s_nxt.st = wdt_pwr_pkg::st_wake_powerup_timer;
          s_nxt.delay = 16'(powerup_timer_cycles);
        end
      end
      wdt_pwr_pkg::st_wake_powerup_timer:
      begin
        if (s_r.delay <= 16'h0001)
        begin
          s_nxt.st = wdt_pwr_pkg::st_run;
        end
        else
        begin
          s_nxt.delay = s_r.delay - 16'h0001;
        end
      end
      default: s_nxt.st = wdt_pwr_pkg::st_run;
    endcase
    // overflow in run resets the device
    if (wdt_ovf && s_r.st == wdt_pwr_pkg::st_run)
    begin
      s_nxt.st = wdt_pwr_pkg::st_run;
      s_nxt.rst_out = 1'b1;
      s_nxt.reset_control_reg = s_r.reset_control_reg & 16'(1 << wdt_pwr_pkg::rc_soft_en_bit);
      s_nxt.reset_control_reg[wdt_pwr_pkg::rc_watchdog_timeout_flag_bit] = 1'b1;
      s_nxt.wdt = '0;
    end
    if (any_rst)
    begin
      s_nxt.rst_out = 1'b1;
      s_nxt.wdt = '0;
      s_nxt.vec = 1'b0;
      s_nxt.md1 = zero16_f();
      s_nxt.md2 = zero16_f();
      s_nxt.need_osc = 1'b1;
      s_nxt.delay = 16'(wdt_pwr_pkg::por_delay_cyc);
      s_nxt.st = wdt_pwr_pkg::st_wake_por;
      if (reset_req.por)
      begin
        s_nxt.reset_control_reg = 16'(3 << wdt_pwr_pkg::rc_por_bit);
        s_nxt.fuse_sel = 1'b1;
        s_nxt.wsrc = fuse_src;
      end
      else if (reset_req.bor)
      begin
        s_nxt.reset_control_reg[wdt_pwr_pkg::rc_bor_bit] = 1'b1;
        s_nxt.reset_control_reg[wdt_pwr_pkg::rc_por_bit] = 1'b0;
        s_nxt.fuse_sel = 1'b1;
        s_nxt.wsrc = fuse_src;
      end
      else
      begin
        s_nxt.wsrc = clock_switch_en ? current_osc_select : fuse_src;
        s_nxt.reset_control_reg[wdt_pwr_pkg::rc_extr_bit] = reset_req.ext;
        s_nxt.reset_control_reg[wdt_pwr_pkg::rc_swr_bit] = reset_req.sw;
        s_nxt.reset_control_reg[wdt_pwr_pkg::rc_watchdog_timeout_flag_bit] = 1'b0;
        s_nxt.reset_control_reg[wdt_pwr_pkg::rc_sleep_bit] = (s_r.st == wdt_pwr_pkg::st_sleep);
        s_nxt.reset_control_reg[wdt_pwr_pkg::rc_idle_bit] = (s_r.st == wdt_pwr_pkg::st_idle);
      end
    end
  end

  function automatic logic [15:0] zero16_f();
    return wdt_pwr_pkg::zero16;
  endfunction

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      s_r <= '0;
      s_r.st <= wdt_pwr_pkg::st_run;
      s_r.reset_control_reg <= 16'(3 << wdt_pwr_pkg::rc_por_bit);
      s_r.run <= {present_mask2, present_mask1};
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  // register read port
  always_comb
  begin
    case (sfr.addr)
      wdt_pwr_pkg::reset_control_addr: sfr_rdata = s_r.reset_control_reg;
      wdt_pwr_pkg::module_disable1_addr: sfr_rdata = s_r.md1;
      wdt_pwr_pkg::module_disable2_addr: sfr_rdata = s_r.md2;
      default: sfr_rdata = wdt_pwr_pkg::zero16;
    endcase
  end

  // upper byte of each config word reads zero
  always_comb
  begin
    case (table_addr)
      wdt_pwr_pkg::oscillator_config_addr: table_rdata = {8'h00, fuse_osc};
      wdt_pwr_pkg::watchdog_config_addr: table_rdata = {8'h00, fuse_wdt};
      wdt_pwr_pkg::brownout_por_config_addr: table_rdata = {8'h00, fuse_borpor};
      wdt_pwr_pkg::code_segment_config_addr: table_rdata = {8'h00, fuse_gs};
      wdt_pwr_pkg::debug_config_addr: table_rdata = {8'h00, fuse_icd};
      default: table_rdata = 24'h000000;
    endcase
  end

  assign device_reset = s_r.rst_out;
  assign cpu_clk_en = (s_r.st == wdt_pwr_pkg::st_run);
  assign periph_clk_en = (s_r.st == wdt_pwr_pkg::st_run) || (s_r.st == wdt_pwr_pkg::st_idle);
  assign osc_run = (s_r.st != wdt_pwr_pkg::st_sleep) || !s_r.need_osc;
  assign clock_fail_monitor_en = (s_r.st != wdt_pwr_pkg::st_sleep);
  assign low_power_rc_osc_en = wdt_on || (s_r.st != wdt_pwr_pkg::st_sleep);
  assign wake_osc_select = s_r.wsrc;
  assign vector_to_handler = s_r.vec;
  assign periph_run = s_r.run & {32{periph_clk_en}};

  property p_wdt_reset;
    @(posedge clk_sys) disable iff (reset)
      (wdt_ovf && s_r.st == wdt_pwr_pkg::st_run && !any_rst) |=> device_reset
        && s_r.reset_control_reg[wdt_pwr_pkg::rc_watchdog_timeout_flag_bit];
  endproperty
  a_wdt_reset: assert property (p_wdt_reset) else $error("no reset on overflow");

  property p_clear;
    @(posedge clk_sys) disable iff (reset)
      (clear_watchdog_instr && !any_rst) |=> s_r.wdt == '0;
  endproperty
  a_clear: assert property (p_clear) else $error("clear ignored");

  property p_sleep_wake;
    @(posedge clk_sys) disable iff (reset)
      (s_r.st == wdt_pwr_pkg::st_sleep && wdt_ovf && !any_rst) |=>
        s_r.reset_control_reg[wdt_pwr_pkg::rc_sleep_bit] && s_r.reset_control_reg[wdt_pwr_pkg::rc_watchdog_timeout_flag_bit]
        && !device_reset;
  endproperty
  a_sleep_wake: assert property (p_sleep_wake) else $error("bad sleep wake");

  property p_sleep_gate;
    @(posedge clk_sys) disable iff (reset)
      (s_r.st == wdt_pwr_pkg::st_sleep) |-> !cpu_clk_en && !periph_clk_en
        && !clock_fail_monitor_en;
  endproperty
  a_sleep_gate: assert property (p_sleep_gate) else $error("clock in sleep");

  property p_idle_wake;
    @(posedge clk_sys) disable iff (reset)
      (s_r.st == wdt_pwr_pkg::st_idle && int_wake_req && !wdt_ovf && !any_rst) |=>
        cpu_clk_en && vector_to_handler && s_r.reset_control_reg[wdt_pwr_pkg::rc_idle_bit];
  endproperty
  a_idle_wake: assert property (p_idle_wake) else $error("slow idle wake");

  property p_por_flags;
    @(posedge clk_sys) disable iff (reset)
      reset_req.por |=> !s_r.reset_control_reg[wdt_pwr_pkg::rc_sleep_bit]
        && !s_r.reset_control_reg[wdt_pwr_pkg::rc_idle_bit];
  endproperty
  a_por_flags: assert property (p_por_flags) else $error("por flags");

  property p_por_delay;
    @(posedge clk_sys) disable iff (reset)
      ($rose(s_r.st == wdt_pwr_pkg::st_wake_por) && !any_rst) |->
        !cpu_clk_en [*8];
  endproperty
  a_por_delay: assert property (p_por_delay) else $error("short por delay");

  property p_md_gate;
    @(posedge clk_sys) disable iff (reset)
      (sfr.we && sfr.addr == wdt_pwr_pkg::module_disable1_addr && !any_rst) |=>
        ##1 s_r.run[15:0] == (present_mask1 & ~$past(sfr.wdata, 2));
  endproperty
  a_md_gate: assert property (p_md_gate) else $error("gate delay");
endmodule // wdt_pwr_ctrl
`default_nettype wire

// [core/wdt_pwr_pkg.sv]
`default_nettype none
package wdt_pwr_pkg;
  // special function register word addresses
  localparam logic [15:0] reset_control_addr = 16'h0740;
  localparam logic [15:0] module_disable1_addr = 16'h0770;
  localparam logic [15:0] module_disable2_addr = 16'h0772;
  // configuration word addresses (table read space)
  localparam logic [23:0] oscillator_config_addr = 24'hf80000;
  localparam logic [23:0] watchdog_config_addr = 24'hf80002;
  localparam logic [23:0] brownout_por_config_addr = 24'hf80004;
  localparam logic [23:0] code_segment_config_addr = 24'hf8000a;
  localparam logic [23:0] debug_config_addr = 24'hf8000c;
  localparam int cfg_used_w = 16;
  localparam int cfg_word_w = 24;
  // field positions
  localparam int wdt_fuse_bit = 15;
  localparam int rc_por_bit = 0;
  localparam int rc_bor_bit = 1;
  localparam int rc_idle_bit = 2;
  localparam int rc_sleep_bit = 3;
  localparam int rc_watchdog_timeout_flag_bit = 4;
  localparam int rc_soft_en_bit = 5;
  localparam int rc_swr_bit = 6;
  localparam int rc_extr_bit = 7;
  localparam int osc_group_lsb = 8;
  localparam int primary_osc_lsb = 0;
  // erased fuse image: every used bit reads 1
  localparam logic [15:0] erased_fuse = 16'hffff;
  localparam logic [15:0] zero16 = 16'h0000;
  // clock source codes (current_osc_select encoding)
  localparam logic [2:0] src_ext_clock = 3'h0;
  localparam logic [2:0] src_fast_rc = 3'h1;
  localparam logic [2:0] src_low_power_rc = 3'h2;
  localparam logic [2:0] src_ext_rc = 3'h3;
  localparam logic [2:0] src_crystal = 3'h4;
  localparam logic [2:0] src_crystal_pll = 3'h5;
  localparam logic [2:0] src_low_power_crystal = 3'h6;
  // timing
  localparam int clk_mhz = 10;
  localparam int por_delay_ns = 10000;
  localparam int por_delay_cyc = (por_delay_ns * clk_mhz) / 1000;
  localparam logic [1:0] power_save_instr_sleep = 2'h0;
  localparam logic [1:0] power_save_instr_idle = 2'h1;

  typedef enum logic [2:0] {
    st_run = 3'h0,
    st_idle = 3'h1,
    st_sleep = 3'h3,
    st_wake_por = 3'h2,
    st_wake_osc = 3'h6,
    st_wake_powerup_timer = 3'h7
  } pwr_state_t;

  typedef struct packed {
    logic por;
    logic bor;
    logic ext;
    logic sw;
  } reset_req_t;

  typedef struct packed {
    logic we;
    logic re;
    logic [15:0] addr;
    logic [15:0] wdata;
  } sfr_bus_t;
endpackage
`default_nettype wire

// [sim/far_side.sv]
`default_nettype none
module far_side (
  input wire logic clk_sys,
  input wire logic osc_run,
  input wire logic low_power_rc_osc_en,
  output logic low_power_rc_osc_tick,
  output logic osc_startup_done,
  output logic pll_lock
);
  timeunit 1ns;
  timeprecision 1ns;
  int div = 0;
  int up = 0;
  // rc tick every 20 system cycles, only while the rc oscillator is on
  always @(posedge clk_sys)
  begin
    div <= (div == 19) ? 0 : div + 1;
    low_power_rc_osc_tick <= low_power_rc_osc_en && div == 19;
    up <= osc_run ? up + 1 : 0;
    osc_startup_done <= osc_run && up >= 30;
    pll_lock <= osc_run && up >= 40;
  end
endmodule // far_side
`default_nettype wire

// [sim/tb.sv]
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int pw = 4;
  localparam int pd = wdt_pwr_pkg::por_delay_cyc;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  wdt_pwr_pkg::reset_req_t reset_req = '0;
  logic low_power_rc_osc_tick, osc_startup_done, pll_lock;
  logic clear_watchdog_instr = 1'b0;
  logic power_save_instr = 1'b0;
  logic [1:0] power_save_operand = 2'h0;
  logic int_wake_req = 1'b0;
  logic clock_switch_en = 1'b1;
  logic [2:0] current_osc_select = wdt_pwr_pkg::src_fast_rc;
  logic low_power_crystal_keep = 1'b0;
  wdt_pwr_pkg::sfr_bus_t sfr = '0;
  logic [15:0] sfr_rdata;
  logic [23:0] table_addr = 24'h000000;
  logic [23:0] table_rdata;
  logic device_reset, cpu_clk_en, periph_clk_en, osc_run, clock_fail_monitor_en;
  logic low_power_rc_osc_en, vector_to_handler;
  logic [2:0] wake_osc_select;
  logic [31:0] periph_run;
  int n_mismatch = 0;
  int num_checks = 0;
  logic seen_rst = 1'b0;
  logic seen_vec = 1'b0;
  always #50 clk_sys = ~clk_sys;
  always @(negedge clk_sys)
  begin
    if (device_reset === 1'b1) seen_rst = 1'b1;
    if (vector_to_handler === 1'b1) seen_vec = 1'b1;
  end
  wdt_pwr_ctrl #(.wdt_width(4), .powerup_timer_cycles(pw), .fuse_wdt(16'h7fff)) i_wdt_pwr_ctrl (
    .clk_sys(clk_sys), .reset(reset), .reset_req(reset_req), .low_power_rc_osc_tick(low_power_rc_osc_tick),
    .clear_watchdog_instr(clear_watchdog_instr), .power_save_instr(power_save_instr),
    .power_save_operand(power_save_operand), .int_wake_req(int_wake_req),
    .clock_switch_en(clock_switch_en), .current_osc_select(current_osc_select),
    .low_power_crystal_keep(low_power_crystal_keep), .osc_startup_done(osc_startup_done),
    .pll_lock(pll_lock), .sfr(sfr), .sfr_rdata(sfr_rdata), .table_addr(table_addr),
    .table_rdata(table_rdata), .device_reset(device_reset), .cpu_clk_en(cpu_clk_en),
    .periph_clk_en(periph_clk_en), .osc_run(osc_run), .wake_osc_select(wake_osc_select),
    .clock_fail_monitor_en(clock_fail_monitor_en), .low_power_rc_osc_en(low_power_rc_osc_en),
    .vector_to_handler(vector_to_handler), .periph_run(periph_run));
  far_side i_far_side (.clk_sys(clk_sys), .osc_run(osc_run),
    .low_power_rc_osc_en(low_power_rc_osc_en), .low_power_rc_osc_tick(low_power_rc_osc_tick),
    .osc_startup_done(osc_startup_done), .pll_lock(pll_lock));

  task automatic wrap_up();
    if (n_mismatch == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    num_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    sfr = '{1'b1, 1'b0, a, d};
    cyc(1);
    sfr = '{1'b0, 1'b1, a, 16'h0000};
  endtask
  task automatic rd(input logic [15:0] a);
    sfr = '{1'b0, 1'b1, a, 16'h0000};
    #1;
  endtask
  task automatic rc_bit(input int b, input logic exp, input string msg);
    rd(wdt_pwr_pkg::reset_control_addr);
    chk(sfr_rdata[b], exp, msg);
  endtask
  task automatic ps(input logic [1:0] op);
    power_save_operand = op;
    power_save_instr = 1'b1;
    cyc(1);
    power_save_instr = 1'b0;
  endtask
  task automatic rreq(input wdt_pwr_pkg::reset_req_t r);
    reset_req = r;
    cyc(1);
    reset_req = '0;
  endtask
  // counts cycles until the cpu clock is back, then waits 3 more cycles; seen_vec catches the vector pulse throughout
  task automatic wake_count(input int lim, output int n);
    n = 0;
    seen_vec = 1'b0;
    while (cpu_clk_en !== 1'b1 && n < lim)
    begin
      cyc(1);
      n++;
    end
    cyc(3);
  endtask

  task automatic t_reset_state();
    logic [23:0] ta [6];
    ta = '{wdt_pwr_pkg::oscillator_config_addr, wdt_pwr_pkg::watchdog_config_addr,
      wdt_pwr_pkg::brownout_por_config_addr, wdt_pwr_pkg::code_segment_config_addr,
      wdt_pwr_pkg::debug_config_addr, 24'hf80006};
    rd(wdt_pwr_pkg::reset_control_addr);
    chk(sfr_rdata, 16'h0003, "reset control after reset");
    rd(wdt_pwr_pkg::module_disable2_addr);
    chk(sfr_rdata, 16'h0000, "disable2 after reset");
    chk(periph_run, 32'hffffffff, "periph_run after reset");
    for (int i = 0; i < 6; i++)
    begin
      table_addr = ta[i];
      #1;
      chk(table_rdata, (i == 5) ? 32'h0 : (i == 1) ? 32'h7fff : 32'hffff, "cfg");
    end
  endtask
  task automatic t_disable();
    wr(wdt_pwr_pkg::module_disable1_addr, 16'h0001);
    chk(periph_run[0], 1'b1, "bit 0 stopped early");
    cyc(1);
    chk(periph_run[0], 1'b0, "bit 0 not stopped");
    wr(wdt_pwr_pkg::module_disable2_addr, 16'h8000);
    chk(periph_run[31], 1'b1, "bit 31 stopped early");
    cyc(1);
    chk(periph_run, 32'h7ffffffe, "disable bits");
    wr(16'h0774, 16'hffff);
    cyc(1);
    rd(16'h0774);
    chk(sfr_rdata, 16'h0000, "unmapped read");
    rd(wdt_pwr_pkg::module_disable1_addr);
    chk(sfr_rdata, 16'h0001, "disable1 readback");
    wr(wdt_pwr_pkg::module_disable1_addr, 16'h0000);
    cyc(1);
    wr(wdt_pwr_pkg::module_disable2_addr, 16'h0000);
    cyc(1);
    chk(periph_run, 32'hffffffff, "re-enable");
  endtask
  task automatic t_idle();
    int n;
    wr(wdt_pwr_pkg::reset_control_addr, 16'h0000);
    ps(wdt_pwr_pkg::power_save_instr_idle);
    chk({cpu_clk_en, periph_clk_en, osc_run}, 3'h3, "idle clocks");
    cyc(3);
    int_wake_req = 1'b1;
    wake_count(5, n);
    int_wake_req = 1'b0;
    chk(n <= 2, 1'b1, "idle wake delay");
    chk(seen_vec, 1'b1, "idle vector");
    rc_bit(wdt_pwr_pkg::rc_idle_bit, 1'b1, "idle flag");
  endtask
  task automatic t_sleep(input logic [2:0] src, input logic keep, input int lo, input int hi);
    int n;
    wr(wdt_pwr_pkg::reset_control_addr, 16'h0000);
    current_osc_select = src;
    low_power_crystal_keep = keep;
    ps(wdt_pwr_pkg::power_save_instr_sleep);
    chk({cpu_clk_en, periph_clk_en, clock_fail_monitor_en}, 3'h0, "sleep clocks");
    chk(osc_run, keep, "osc in sleep");
    cyc(3);
    int_wake_req = 1'b1;
    wake_count(1000, n);
    int_wake_req = 1'b0;
    chk(n >= lo && n <= hi, 1'b1, "sleep wake delay");
    chk(wake_osc_select, src, "wake source");
    chk(seen_vec, 1'b1, "sleep vector");
    rc_bit(wdt_pwr_pkg::rc_sleep_bit, 1'b1, "sleep flag");
  endtask
  task automatic t_wdt();
    int n;
    wr(wdt_pwr_pkg::reset_control_addr, 16'h0020);
    seen_rst = 1'b0;
    repeat (30)
    begin
      cyc(100);
      clear_watchdog_instr = 1'b1;
      cyc(1);
      clear_watchdog_instr = 1'b0;
    end
    chk(seen_rst, 1'b0, "reset despite clearing");
    for (n = 0; n < 400 && !seen_rst; n++) cyc(1);
    chk(seen_rst, 1'b1, "no overflow reset");
    wake_count(400, n);
    rc_bit(wdt_pwr_pkg::rc_watchdog_timeout_flag_bit, 1'b1, "timeout flag");
    wr(wdt_pwr_pkg::reset_control_addr, 16'h0020);
    ps(wdt_pwr_pkg::power_save_instr_sleep);
    chk(low_power_rc_osc_en, 1'b1, "rc off in sleep");
    seen_rst = 1'b0;
    wake_count(600, n);
    chk(n < 600 && !seen_rst, 1'b1, "watchdog wake");
    rc_bit(wdt_pwr_pkg::rc_sleep_bit, 1'b1, "sleep flag");
    rc_bit(wdt_pwr_pkg::rc_watchdog_timeout_flag_bit, 1'b1, "timeout flag");
    wr(wdt_pwr_pkg::reset_control_addr, 16'h0020);
    ps(wdt_pwr_pkg::power_save_instr_idle);
    seen_rst = 1'b0;
    wake_count(600, n);
    chk(n < 600 && !seen_rst, 1'b1, "idle watchdog wake");
    rc_bit(wdt_pwr_pkg::rc_idle_bit, 1'b1, "idle flag on timeout");
    rc_bit(wdt_pwr_pkg::rc_watchdog_timeout_flag_bit, 1'b1, "timeout flag in idle");
    wr(wdt_pwr_pkg::reset_control_addr, 16'h0000);
  endtask
  task automatic t_resets();
    int n;
    current_osc_select = wdt_pwr_pkg::src_fast_rc;
    ps(wdt_pwr_pkg::power_save_instr_sleep);
    rreq('{1'b0, 1'b0, 1'b1, 1'b0});
    wake_count(400, n);
    rc_bit(wdt_pwr_pkg::rc_sleep_bit, 1'b1, "ext reset sleep flag");
    rc_bit(wdt_pwr_pkg::rc_extr_bit, 1'b1, "ext reset flag");
    ps(wdt_pwr_pkg::power_save_instr_idle);
    rreq('{1'b0, 1'b0, 1'b1, 1'b0});
    wake_count(400, n);
    rc_bit(wdt_pwr_pkg::rc_idle_bit, 1'b1, "ext reset idle flag");
    rreq('{1'b1, 1'b0, 1'b0, 1'b0});
    wake_count(400, n);
    rc_bit(wdt_pwr_pkg::rc_sleep_bit, 1'b0, "por sleep flag");
    rc_bit(wdt_pwr_pkg::rc_idle_bit, 1'b0, "por idle flag");
    rreq('{1'b0, 1'b0, 1'b0, 1'b1});
    wake_count(400, n);
    rc_bit(wdt_pwr_pkg::rc_swr_bit, 1'b1, "sw reset flag");
    ps(wdt_pwr_pkg::power_save_instr_sleep);
    rreq('{1'b0, 1'b1, 1'b0, 1'b0});
    wake_count(400, n);
    chk(wake_osc_select, wdt_pwr_pkg::erased_fuse[wdt_pwr_pkg::osc_group_lsb +: 3],
      "bor wake source");
    rc_bit(wdt_pwr_pkg::rc_bor_bit, 1'b1, "bor flag");
    rc_bit(wdt_pwr_pkg::rc_por_bit, 1'b0, "bor por flag");
  endtask

  initial
  begin
    cyc(5);
    reset = 1'b0;
    cyc(1);
    t_reset_state();
    t_disable();
    t_idle();
    t_sleep(wdt_pwr_pkg::src_fast_rc, 1'b0, pd, pd + 4);
    t_sleep(wdt_pwr_pkg::src_crystal_pll, 1'b0, pd + pw, pd + pw + 8);
    t_sleep(wdt_pwr_pkg::src_low_power_crystal, 1'b1, pd, pd + 4);
    t_wdt();
    t_resets();
    wrap_up();
  end
  initial
  begin
    #3ms;
    n_mismatch++;
    wrap_up();
  end
endmodule // tb
`default_nettype wire
